// ### rtl/can_receive_filter_path.sv
// CAN receive queue, acceptance filter, configuration lock and quantum prescaler
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module can_receive_filter_path (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_byte_wr,
  input wire logic [3:0] rx_byte_idx,
  input wire logic [7:0] rx_byte,
  input wire logic rx_frame_done,
  input wire logic rx_frame_ok,
  input wire logic tx_frame_start,
  input wire logic arb_lost,
  input wire logic tx_bit,
  input wire logic [7:0] rx_err_count,
  input wire logic [7:0] tx_err_count,
  input wire logic osc_clk,
  input wire logic power_down,
  input wire logic special_mode,
  output logic bus_transmit_output,
  output logic ack_enable,
  output logic time_quantum_tick,
  output logic rx_irq,
  output logic overrun_irq
);
  typedef struct packed {
    can_rx_pkg::apb_st_t ap;
    logic [31:0] prdata;
    logic err;
    logic init_request;
    logic init_acknowledge;
    logic module_enable_bit;
    logic enable_written;
    logic clock_source_select;
    logic loopback;
    logic [7:0] btr0;
    logic [7:0] btr1;
    logic rx_ie;
    logic ovr_ie;
    logic ovr_flag;
    can_rx_pkg::filt_mode_t mode;
    logic [7:0][7:0] pattern;
    logic [7:0][7:0] mask;
    logic [5:0][2:0] slot_hit;
    logic [3:0][7:0] id_bytes;
    logic [2:0] head;
    logic [2:0] tail;
    logic [2:0] count;
    logic own;
    logic [5:0] psc_cnt;
    logic tq;
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic rx_irq;
    logic ovr_irq;
    logic tx_out;
  } state_t;

  state_t r;
  state_t n;
  logic [31:0] mem_rd;
  logic [7:0] byte_match;
  logic [7:0] hits;
  logic [5:0] widx;

  function automatic logic known_reg(input logic [5:0] idx);
    known_reg = (idx <= can_rx_pkg::IDX_TXERR) ||
      (idx >= can_rx_pkg::IDX_IDAR0 && idx < can_rx_pkg::IDX_FG0 + 6'h04);
  endfunction

  function automatic logic [1:0] id_byte_of(input can_rx_pkg::filt_mode_t m, input int i);
    case (m)
      can_rx_pkg::FM_32: id_byte_of = 2'(i % 4);
      can_rx_pkg::FM_16: id_byte_of = 2'(i % 2);
      default: id_byte_of = 2'h0;
    endcase
  endfunction

  function automatic logic [2:0] next_slot(input logic [2:0] s);
    next_slot = (s == can_rx_pkg::SLOT_LAST) ? 3'h0 : s + 3'h1;
  endfunction

  assign widx = paddr[7:2];

  // Each pattern byte against the identifier byte its mode assigns; mask bits drop out
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_cmp
      assign byte_match[gi] =
        ((r.id_bytes[id_byte_of(r.mode, gi)] ^ r.pattern[gi]) & ~r.mask[gi]) == 8'h00;
    end
  endgenerate

  always_comb
  begin
    unique case (r.mode)
      can_rx_pkg::FM_32: hits = {6'h00, &byte_match[7:4], &byte_match[3:0]};
      can_rx_pkg::FM_16: hits = {4'h0, &byte_match[7:6], &byte_match[5:4],
        &byte_match[3:2], &byte_match[1:0]};
      can_rx_pkg::FM_8: hits = byte_match;
      can_rx_pkg::FM_CLOSED: hits = 8'h00;
    endcase
  end

  rx_msg_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(rx_byte_wr && rx_byte_idx < can_rx_pkg::MSG_BYTES),
    .wr_addr({r.tail, rx_byte_idx[3:2]}),
    .wr_lane(rx_byte_idx[1:0]),
    .wr_data(rx_byte),
    .rd_addr({r.head, paddr[3:2]}),
    .rd_data(mem_rd)
  );

  always_comb
  begin
    logic [7:0] rd8;
    logic [7:0] wd;
    logic do_wr;
    logic unlocked;
    logic accept;
    logic push;
    logic pop;
    logic [2:0] first_hit;
    logic base_tick;
    rd8 = 8'h00;
    wd = pwdata[7:0];
    do_wr = 1'b0;
    unlocked = r.init_request && r.init_acknowledge;
    accept = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    first_hit = 3'h0;
    base_tick = 1'b0;
    n = r;
    n.rx_irq = 1'b0;
    n.ovr_irq = 1'b0;
    n.tq = 1'b0;

    // Read value for the addressed word
    if (widx >= can_rx_pkg::IDX_IDAR0 && widx < can_rx_pkg::IDX_IDMR0)
    begin
      rd8 = r.pattern[widx[2:0]];
    end
    else if (widx >= can_rx_pkg::IDX_IDMR0 && widx < can_rx_pkg::IDX_FG0)
    begin
      rd8 = r.mask[widx[2:0]];
    end
    else
    begin
      case (widx)
        can_rx_pkg::IDX_CTL0: rd8[can_rx_pkg::CTL0_INIT_REQUEST] = r.init_request;
        can_rx_pkg::IDX_CTL1:
        begin
          rd8[can_rx_pkg::CTL1_ENABLE] = r.module_enable_bit;
          rd8[can_rx_pkg::CTL1_CLOCK_SOURCE_SELECT] = r.clock_source_select;
          rd8[can_rx_pkg::CTL1_LOOP] = r.loopback;
          rd8[can_rx_pkg::CTL1_INIT_ACKNOWLEDGE] = r.init_acknowledge;
        end
        can_rx_pkg::IDX_BTR0: rd8 = r.btr0;
        can_rx_pkg::IDX_BTR1: rd8 = r.btr1;
        can_rx_pkg::IDX_RFLG:
        begin
          rd8[can_rx_pkg::RFLG_RXF] = r.count != 3'h0;
          rd8[can_rx_pkg::RFLG_OVR] = r.ovr_flag;
        end
        can_rx_pkg::IDX_RIER:
        begin
          rd8[can_rx_pkg::RIER_RXIE] = r.rx_ie;
          rd8[can_rx_pkg::RIER_OVRIE] = r.ovr_ie;
        end
        can_rx_pkg::IDX_IDAC:
        begin
          rd8[can_rx_pkg::IDAC_MODE_LSB+:2] = r.mode;
          rd8[2:0] = r.slot_hit[r.head];
        end
        can_rx_pkg::IDX_RXERR: rd8 = rx_err_count;
        can_rx_pkg::IDX_TXERR: rd8 = tx_err_count;
        default: rd8 = 8'h00;
      endcase
    end

    // APB: setup, one wait cycle for the registered store read, then ready
    unique case (r.ap)
      can_rx_pkg::AP_IDLE:
      begin
        if (psel && !penable)
        begin
          n.ap = can_rx_pkg::AP_WAIT;
        end
      end
      can_rx_pkg::AP_WAIT:
      begin
        n.ap = can_rx_pkg::AP_DONE;
        n.err = !known_reg(widx);
        n.prdata = !known_reg(widx) ? 32'h0000_0000 :
          (widx >= can_rx_pkg::IDX_FG0) ? mem_rd : {24'h000000, rd8};
      end
      can_rx_pkg::AP_DONE:
      begin
        n.ap = can_rx_pkg::AP_IDLE;
        do_wr = psel && penable && pwrite;
      end
      default: n.ap = can_rx_pkg::AP_IDLE;
    endcase

    // Register writes; the error counter words take no write at all
    if (do_wr)
    begin
      if (widx >= can_rx_pkg::IDX_IDAR0 && widx < can_rx_pkg::IDX_IDMR0 && unlocked)
      begin
        n.pattern[widx[2:0]] = wd;
      end
      else if (widx >= can_rx_pkg::IDX_IDMR0 && widx < can_rx_pkg::IDX_FG0 && unlocked)
      begin
        n.mask[widx[2:0]] = wd;
      end
      else
      begin
        case (widx)
          can_rx_pkg::IDX_CTL0: n.init_request = wd[can_rx_pkg::CTL0_INIT_REQUEST];
          can_rx_pkg::IDX_CTL1:
          begin
            // Only one enable write after reset outside special mode, so stray code cannot switch it off
            if (special_mode || !r.enable_written)
            begin
              n.module_enable_bit = wd[can_rx_pkg::CTL1_ENABLE];
              n.enable_written = 1'b1;
            end
            if (unlocked)
            begin
              n.clock_source_select = wd[can_rx_pkg::CTL1_CLOCK_SOURCE_SELECT];
              n.loopback = wd[can_rx_pkg::CTL1_LOOP];
            end
          end
          can_rx_pkg::IDX_BTR0: n.btr0 = unlocked ? wd : r.btr0;
          can_rx_pkg::IDX_BTR1: n.btr1 = unlocked ? wd : r.btr1;
          can_rx_pkg::IDX_RFLG:
          begin
            pop = wd[can_rx_pkg::RFLG_RXF] && r.count != 3'h0;
            if (wd[can_rx_pkg::RFLG_OVR])
            begin
              n.ovr_flag = 1'b0;
            end
          end
          can_rx_pkg::IDX_RIER:
          begin
            n.rx_ie = wd[can_rx_pkg::RIER_RXIE];
            n.ovr_ie = wd[can_rx_pkg::RIER_OVRIE];
          end
          can_rx_pkg::IDX_IDAC:
          begin
            if (unlocked)
            begin
              n.mode = can_rx_pkg::filt_mode_t'(wd[can_rx_pkg::IDAC_MODE_LSB+:2]);
            end
          end
          default: n.init_request = r.init_request;
        endcase
      end
    end
    // Acknowledge follows the request one cycle later
    n.init_acknowledge = r.init_request;

    // Identifier bytes are shadowed as they stream in, for the filter
    if (rx_byte_wr && rx_byte_idx < can_rx_pkg::ID_BYTES)
    begin
      n.id_bytes[rx_byte_idx[1:0]] = rx_byte;
    end

    // Own frame until arbitration is lost; then it is a receiver like any other
    if (tx_frame_start)
    begin
      n.own = 1'b1;
    end
    if (arb_lost)
    begin
      n.own = 1'b0;
    end

    for (int i = 7; i >= 0; i--)
    begin
      if (hits[i])
      begin
        first_hit = 3'(i);
      end
    end

    if (rx_frame_done)
    begin
      n.own = 1'b0;
      // Rejected or errored frames stay in the background slot and get overwritten
      accept = rx_frame_ok && (!r.own || r.loopback) && (hits != 8'h00);
      if (accept && r.count == can_rx_pkg::QUEUE_DEPTH)
      begin
        n.ovr_flag = 1'b1;
        n.ovr_irq = r.ovr_ie;
      end
      else if (accept)
      begin
        push = 1'b1;
        n.slot_hit[r.tail] = first_hit;
        n.tail = next_slot(r.tail);
        n.rx_irq = r.rx_ie;
      end
    end

    // A push in the same cycle as a clear keeps the flag set
    if (pop)
    begin
      n.head = next_slot(r.head);
    end
    n.count = r.count + 3'(push) - 3'(pop);

    // Quantum prescaler on bus clock or the sampled oscillator
    n.osc_s1 = osc_clk;
    n.osc_s2 = r.osc_s1;
    n.osc_s3 = r.osc_s2;
    if (r.clock_source_select && can_rx_pkg::HAS_CLOCK_GEN)
    begin
      base_tick = 1'b1;
    end
    else
    begin
      base_tick = r.osc_s2 && !r.osc_s3;
    end
    if (!r.module_enable_bit)
    begin
      n.psc_cnt = 6'h00;
    end
    else if (base_tick)
    begin
      if (r.psc_cnt >= r.btr0[5:0])
      begin
        n.psc_cnt = 6'h00;
        n.tq = 1'b1;
      end
      else
      begin
        n.psc_cnt = r.psc_cnt + 6'h01;
      end
    end

    // Forced recessive as soon as init is requested, not when acknowledged
    if (power_down || n.init_request || !r.module_enable_bit)
    begin
      n.tx_out = can_rx_pkg::RECESSIVE;
    end
    else
    begin
      n.tx_out = tx_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.btr0 <= can_rx_pkg::BTR_RESET;
      r.btr1 <= can_rx_pkg::BTR_RESET;
      r.tx_out <= can_rx_pkg::RECESSIVE;
    end
    else
    begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = penable && r.ap == can_rx_pkg::AP_DONE;
  assign pslverr = pready && r.err;
  assign bus_transmit_output = r.tx_out;
  assign ack_enable = !r.own || r.loopback;
  assign time_quantum_tick = r.tq;
  assign rx_irq = r.rx_irq;
  assign overrun_irq = r.ovr_irq;
endmodule

// ### rtl/can_rx_pkg.sv
// Package: register map, field layout and constants of the CAN receive path
// Contract
// - Five-deep receive queue behind one window
// - Each receive buffer holds fifteen bytes
// - Full flag set while foreground holds message
// - Filter during reception, queue valid frame, interrupt
// - Errored or rejected frames are simply overwritten
// - Own frames not queued, interrupted or acknowledged
// - Loopback treats own frames like others
// - Lost arbitration turns device into receiver
// - Full queue drops new frame, signals overrun
// - Masked identifier bits are don't care
// - Lowest matching filter reported in hit field
// - 32-bit mode: two filters, one per bank
// - 16-bit mode: four filters, two per bank
// - 8-bit mode: eight filters on first byte
// - Closed mode never sets the full flag
// - Error counters cannot be altered by software
// - Configuration writes need init handshake complete
// - Transmit pin recessive in power-down or init
// - Module enable writable once in normal modes
// - Clock source bit picks oscillator or bus clock
// - Prescaler divides protocol clock into quantum tick
package can_rx_pkg;
  // Register word indexes; byte address is four times the index
  localparam logic [5:0] IDX_CTL0 = 6'h00;
  localparam logic [5:0] IDX_CTL1 = 6'h01;
  localparam logic [5:0] IDX_BTR0 = 6'h02;
  localparam logic [5:0] IDX_BTR1 = 6'h03;
  localparam logic [5:0] IDX_RFLG = 6'h04;
  localparam logic [5:0] IDX_RIER = 6'h05;
  localparam logic [5:0] IDX_IDAC = 6'h06;
  localparam logic [5:0] IDX_RXERR = 6'h07;
  localparam logic [5:0] IDX_TXERR = 6'h08;
  localparam logic [5:0] IDX_IDAR0 = 6'h10;
  localparam logic [5:0] IDX_IDMR0 = 6'h18;
  localparam logic [5:0] IDX_FG0 = 6'h20;
  // Field positions
  localparam int CTL0_INIT_REQUEST = 0;
  localparam int CTL1_ENABLE = 7;
  localparam int CTL1_CLOCK_SOURCE_SELECT = 6;
  localparam int CTL1_LOOP = 5;
  localparam int CTL1_INIT_ACKNOWLEDGE = 0;
  localparam int RFLG_RXF = 0;
  localparam int RFLG_OVR = 1;
  localparam int RIER_RXIE = 0;
  localparam int RIER_OVRIE = 1;
  localparam int IDAC_MODE_LSB = 4;
  // Sizes
  localparam logic [2:0] QUEUE_DEPTH = 3'h5;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [3:0] MSG_BYTES = 4'hf;
  localparam logic [3:0] ID_BYTES = 4'h4;
  localparam int MEM_WORDS = 24;
  // Reset values and options
  localparam logic [7:0] BTR_RESET = 8'h00;
  localparam logic RECESSIVE = 1'b1;
  localparam logic HAS_CLOCK_GEN = 1'b1;
  typedef enum logic [1:0] {FM_32 = 2'h0, FM_16 = 2'h1, FM_8 = 2'h2, FM_CLOSED = 2'h3} filt_mode_t;
  typedef enum logic [1:0] {AP_IDLE = 2'h0, AP_WAIT = 2'h1, AP_DONE = 2'h3} apb_st_t;
endpackage

// ### rtl/rx_msg_store.sv
// Message store: six 16-byte slots, byte writes, registered word reads
`timescale 1ns/1ps
module rx_msg_store (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [1:0] wr_lane,
  input wire logic [7:0] wr_data,
  input wire logic [4:0] rd_addr,
  output logic [31:0] rd_data
);
  typedef struct packed {
    logic [can_rx_pkg::MEM_WORDS-1:0][3:0][7:0] mem;
    logic [31:0] rd;
  } store_t;

  store_t r;
  store_t n;

  always_comb
  begin
    n = r;
    if (wr_en && wr_addr < 5'(can_rx_pkg::MEM_WORDS))
    begin
      n.mem[wr_addr][wr_lane] = wr_data;
    end
    // Unused addresses read zero rather than wrapping
    n.rd = (rd_addr < 5'(can_rx_pkg::MEM_WORDS)) ? r.mem[rd_addr] : 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign rd_data = r.rd;
endmodule

// ### dv/can_rx_path_assertions.sv
// Checker: port relations of the CAN receive path
`timescale 1ns/1ps
module can_rx_path_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic rx_frame_done,
  input wire logic rx_frame_ok,
  input wire logic tx_frame_start,
  input wire logic arb_lost,
  input wire logic power_down,
  input wire logic bus_transmit_output,
  input wire logic ack_enable,
  input wire logic rx_irq,
  input wire logic overrun_irq
);
  logic own_r;
  // Own frame runs from its start until lost arbitration or frame end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      own_r <= 1'b0;
    else if (tx_frame_start)
      own_r <= 1'b1;
    else if (arb_lost || rx_frame_done)
      own_r <= 1'b0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence good_done;
    rx_frame_done && rx_frame_ok;
  endsequence
  sequence bad_done;
    rx_frame_done && !rx_frame_ok;
  endsequence
  sequence apb_setup;
    psel && !penable;
  endsequence
  chk_rx_cause: assert property (rx_irq |-> $past(rx_frame_done && rx_frame_ok))
    else $error("rx irq without good frame");
  chk_irq_single: assert property (good_done |=> !(rx_irq && overrun_irq) ##1 !rx_irq)
    else $error("rx irq not a single pulse");
  chk_bad_quiet: assert property (bad_done |=> !rx_irq && !overrun_irq)
    else $error("bad frame raised irq");
  chk_ovr_cause: assert property (overrun_irq |-> $past(rx_frame_done && rx_frame_ok))
    else $error("overrun irq without good frame");
  chk_own_noack: assert property (!ack_enable |-> own_r)
    else $error("ack withheld outside own frame");
  chk_arb_ack: assert property (arb_lost |=> ack_enable)
    else $error("no ack after lost arbitration");
  chk_pd_recessive: assert property (power_down [*2] |-> bus_transmit_output)
    else $error("tx not recessive in power down");
  chk_ready_time: assert property (apb_setup |=> !pready ##1 pready)
    else $error("apb answer timing wrong");
endmodule

bind can_receive_filter_path can_rx_path_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .rx_frame_done(rx_frame_done),
  .rx_frame_ok(rx_frame_ok), .tx_frame_start(tx_frame_start), .arb_lost(arb_lost),
  .power_down(power_down), .bus_transmit_output(bus_transmit_output),
  .ack_enable(ack_enable), .rx_irq(rx_irq), .overrun_irq(overrun_irq));

// ### dv/can_node_model.sv
// Partner: protocol engine side delivering frames into the receive path
`timescale 1ns/1ps
module can_node_model (
  input wire logic pclk,
  output logic rx_byte_wr,
  output logic [3:0] rx_byte_idx,
  output logic [7:0] rx_byte,
  output logic rx_frame_done,
  output logic rx_frame_ok,
  output logic tx_frame_start,
  output logic arb_lost
);
  initial
  begin
    {rx_byte_wr, rx_byte_idx, rx_byte, rx_frame_done, rx_frame_ok} = '0;
    {tx_frame_start, arb_lost} = '0;
  end
  // Bytes 1..3 are c1..c3, payload bytes 4..14 are 40 plus index
  task automatic send(input logic [7:0] id0, input logic ok, input logic own, input logic arb);
    if (own)
    begin
      @(posedge pclk);
      tx_frame_start <= 1'b1;
    end
    for (int i = 0; i < 15; i++)
    begin
      @(posedge pclk);
      tx_frame_start <= 1'b0;
      rx_byte_wr <= 1'b1;
      rx_byte_idx <= i[3:0];
      rx_byte <= (i == 0) ? id0 : (i < 4) ? 8'hc0 + i[7:0] : 8'h40 + i[7:0];
      arb_lost <= arb && (i == 5);
    end
    @(posedge pclk);
    // Released lines show the inverse so stale values cannot pass
    rx_byte_wr <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_byte_idx <= ~rx_byte_idx;
    rx_frame_done <= 1'b1;
    rx_frame_ok <= ok;
    @(posedge pclk);
    rx_frame_done <= 1'b0;
    rx_frame_ok <= ~ok;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// ### dv/can_receive_filter_path_bench.sv
// Testbench: register access, filtering and queueing of the receive path
`timescale 1ns/1ps
module can_receive_filter_path_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, osc_clk = 1'b0, power_down = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, rx_byte_wr, rx_frame_done, rx_frame_ok, tx_frame_start, arb_lost;
  logic [3:0] rx_byte_idx;
  logic [7:0] rx_byte;
  logic bus_transmit_output, ack_enable, time_quantum_tick, rx_irq, overrun_irq;
  logic [2:0] hits [5] = '{3'h3, 3'h6, 3'h3, 3'h3, 3'h3};
  int error_cnt = 0, num_checks = 0, irq_cnt = 0, ovr_cnt = 0, tick_cnt = 0, nack_cnt = 0;
  always #12.5 pclk = ~pclk;
  always #200 osc_clk = ~osc_clk;
  // Counted on the falling edge so a reset of a counter never races the sampling
  always @(negedge pclk)
  begin
    nack_cnt += (ack_enable === 1'b0);
    irq_cnt += (rx_irq === 1'b1);
    ovr_cnt += (overrun_irq === 1'b1);
    tick_cnt += (time_quantum_tick === 1'b1);
  end
  can_node_model u_node (.pclk, .rx_byte_wr, .rx_byte_idx, .rx_byte, .rx_frame_done,
    .rx_frame_ok, .tx_frame_start, .arb_lost);
  can_receive_filter_path u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_byte_wr, .rx_byte_idx, .rx_byte, .rx_frame_done,
    .rx_frame_ok, .tx_frame_start, .arb_lost, .tx_bit(1'b0), .rx_err_count(8'h5a),
    .tx_err_count(8'h33), .osc_clk, .power_down, .special_mode(1'b0), .bus_transmit_output,
    .ack_enable, .time_quantum_tick, .rx_irq, .overrun_irq);
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    check(name, rd, exp);
  endtask
  task automatic give_verdict;
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #500000;
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctl1", can_rx_pkg::IDX_CTL1, 32'h0);
    apb(1'b1, can_rx_pkg::IDX_IDAC, 32'h20);
    rchk("idac locked", can_rx_pkg::IDX_IDAC, 32'h0);
    apb(1'b1, can_rx_pkg::IDX_CTL0, 32'h1);
    rchk("init ack", can_rx_pkg::IDX_CTL1, 32'h1);
    check("tx in init", {31'h0, bus_transmit_output}, 32'h1);
    apb(1'b1, can_rx_pkg::IDX_CTL1, 32'h80);
    apb(1'b1, can_rx_pkg::IDX_BTR0, 32'h3);
    apb(1'b1, can_rx_pkg::IDX_IDAC, 32'h20);
    apb(1'b1, can_rx_pkg::IDX_RIER, 32'h3);
    // Filters 3 and 5 both take 15, filter 6 takes 2x with low nibble masked
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b1, can_rx_pkg::IDX_IDAR0 + k[5:0],
        (k == 3 || k == 5) ? 32'h15 : (k == 6) ? 32'h20 : 32'h80);
      apb(1'b1, can_rx_pkg::IDX_IDMR0 + k[5:0], (k == 6) ? 32'h0f : 32'h0);
    end
    apb(1'b1, can_rx_pkg::IDX_CTL0, 32'h0);
    rchk("ctl1 online", can_rx_pkg::IDX_CTL1, 32'h80);
    check("tx online", {31'h0, bus_transmit_output}, 32'h0);
    apb(1'b1, can_rx_pkg::IDX_CTL1, 32'h0);
    rchk("enable kept", can_rx_pkg::IDX_CTL1, 32'h80);
    apb(1'b1, can_rx_pkg::IDX_RXERR, 32'hff);
    rchk("rx errors", can_rx_pkg::IDX_RXERR, 32'h5a);
    tick_cnt = 0;
    repeat (640) @(posedge pclk);
    check("osc ticks", tick_cnt, 10);
    u_node.send(8'h15, 1'b1, 1'b0, 1'b0);
    rchk("rxf", can_rx_pkg::IDX_RFLG, 32'h1);
    rchk("hit", can_rx_pkg::IDX_IDAC, 32'h23);
    rchk("fg1", can_rx_pkg::IDX_FG0 + 6'h1, 32'h47464544);
    apb(1'b0, can_rx_pkg::IDX_FG0 + 6'h3, 32'h0);
    check("fg3", rd & 32'h00ffffff, 32'h004e4d4c);
    // Four words past the window's last word, where a loose decode would show the foreground slot
    apb(1'b0, 6'h27, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    u_node.send(8'h99, 1'b1, 1'b0, 1'b0);
    u_node.send(8'h2a, 1'b0, 1'b0, 1'b0);
    u_node.send(8'h2a, 1'b1, 1'b1, 1'b0);
    u_node.send(8'h2a, 1'b1, 1'b1, 1'b1);
    check("own no ack", nack_cnt, 22);
    repeat (4) u_node.send(8'h15, 1'b1, 1'b0, 1'b0);
    check("rx irqs", irq_cnt, 5);
    check("overruns", ovr_cnt, 1);
    rchk("ovr flag", can_rx_pkg::IDX_RFLG, 32'h3);
    for (int i = 0; i < 5; i++)
    begin
      rchk("queue hit", can_rx_pkg::IDX_IDAC, {29'h4, hits[i]});
      rchk("queue id", can_rx_pkg::IDX_FG0,
        {24'hc3c2c1, hits[i] == 3'h6 ? 8'h2a : 8'h15});
      apb(1'b1, can_rx_pkg::IDX_RFLG, 32'h1);
      rchk("advance", can_rx_pkg::IDX_RFLG, (i < 4) ? 32'h3 : 32'h2);
    end
    u_node.send(8'h15, 1'b1, 1'b0, 1'b0);
    rchk("resumed", can_rx_pkg::IDX_RFLG, 32'h3);
    apb(1'b1, can_rx_pkg::IDX_CTL0, 32'h1);
    apb(1'b1, can_rx_pkg::IDX_CTL1, 32'he0);
    check("tx init", {31'h0, bus_transmit_output}, 32'h1);
    apb(1'b1, can_rx_pkg::IDX_CTL0, 32'h0);
    tick_cnt = 0;
    repeat (40) @(posedge pclk);
    check("bus ticks", tick_cnt, 10);
    u_node.send(8'h15, 1'b1, 1'b1, 1'b0);
    check("loopback irq", irq_cnt, 7);
    apb(1'b1, can_rx_pkg::IDX_CTL0, 32'h1);
    apb(1'b1, can_rx_pkg::IDX_IDAC, 32'h30);
    apb(1'b1, can_rx_pkg::IDX_CTL0, 32'h0);
    u_node.send(8'h15, 1'b1, 1'b0, 1'b0);
    check("closed irq", irq_cnt, 7);
    power_down <= 1'b1;
    repeat (3) @(posedge pclk);
    check("tx power down", {31'h0, bus_transmit_output}, 32'h1);
    power_down <= 1'b0;
    give_verdict();
  end
endmodule
